// *** hdl/nvram_bus_pkg.sv ***
// Constants shared by the byte-wide and expanded bus interface
// Function
// (RL1) A high reset input places the whole interface in its reset state.
// (RL2) Outside party pulls fetch enable low, only in reset, for the loader.
// (RL3) Internal memory disable low sends every access to the expanded bus.
// (RL4) Fifteen-bit non-multiplexed address bus drives battery-backed SRAM.
// (RL5) SRAM address bits 13 and 14 are driven inverted from logical address.
// (RL6) Eight-bit two-way SRAM data bus: driven on writes, sampled on reads.
// (RL7) SRAM write enable follows map and partition; never in program space.
// (RL8) Primary SRAM accesses assert the active-low primary chip select.
// (RL9) Secondary chip select only for the second 32k data-only bank.
// (RL10) Both chip selects held high during battery-backup state.
// (RL11) Partition boundary splits SRAM into program and data; changeable.
// (RL12) SRAM may be 8 kbytes or 32 kbytes.
// (RL13) Expanded cycles multiplex low address and data; latch strobe pulses.
// (RL14) Expanded cycles drive the high address byte on the high port.
// (RL15) Active-low fetch enable reads instructions from external memory.
// (RL16) External data uses active-low store and load strobes.
// (RL17) Addresses 0000h to 7FFFh map to SRAM; the rest to expanded bus. With the 8k size the code sends 2000h-7FFFh out too, except bank-2 data.
// (RL18) Secondary bank accesses never appear on the expanded-bus ports.
// (RL19) Never both chip selects at once; write enable off without a select.
package nvram_bus_pkg;
  localparam int ADDR_W = 16;
  localparam int SRAM_ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] SRAM_LIMIT_32K = 16'h8000;
  localparam logic [ADDR_W-1:0] SRAM_LIMIT_8K = 16'h2000;
  localparam int INV_LO = 13;
  localparam int INV_HI = 14;
  localparam logic [3:0] SRAM_CYCLES = 4'h2;
  localparam logic [3:0] ALE_CYCLES = 4'h2;
  localparam logic [3:0] STROBE_CYCLES = 4'h4;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SRAM,
    ST_EXP_ADDR,
    ST_EXP_HOLD,
    ST_EXP_STROBE,
    ST_DONE
  } bus_state_t;
endpackage : nvram_bus_pkg

// *** hdl/nvram_addr_decode.sv ***
// Address decode and write protection for the byte-wide SRAM bus
`timescale 1ns/1ps
module nvram_addr_decode
  import nvram_bus_pkg::*;
(
  // Access description
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic is_code_in,
  input wire logic bank2_in,
  // Configuration
  input wire logic [SRAM_ADDR_W-1:0] partition_in,
  input wire logic sram_size_32k_in,
  input wire logic ext_only_in,
  // Decode result
  output logic sel_primary_out,
  output logic sel_secondary_out,
  output logic write_ok_out,
  output logic [SRAM_ADDR_W-1:0] sram_addr_out
);
  logic [ADDR_W-1:0] limit;
  logic in_low_32k;

  always_comb begin
    limit = sram_size_32k_in ? SRAM_LIMIT_32K : SRAM_LIMIT_8K; // RL12
    in_low_32k = addr_in < SRAM_LIMIT_32K; // RL17
    sel_secondary_out = !ext_only_in && bank2_in && !is_code_in
      && in_low_32k; // RL9 RL3
    sel_primary_out = !ext_only_in && !sel_secondary_out
      && (addr_in < limit); // RL8 RL17 RL19
    // Program segment below partition is write protected
    write_ok_out = !is_code_in && (sel_secondary_out
      || (sel_primary_out
      && addr_in[SRAM_ADDR_W-1:0] >= partition_in)); // RL7 RL11
    sram_addr_out = addr_in[SRAM_ADDR_W-1:0]; // RL4
    sram_addr_out[INV_HI] = ~addr_in[INV_HI]; // RL5
    sram_addr_out[INV_LO] = ~addr_in[INV_LO]; // RL5
  end
endmodule : nvram_addr_decode

// *** hdl/nvram_bus_ctrl.sv ***
// Byte-wide SRAM and multiplexed expanded bus controller
`timescale 1ns/1ps
module nvram_bus_ctrl
  import nvram_bus_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Processor request
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic req_is_code_in,
  input wire logic req_bank2_in,
  input wire logic [ADDR_W-1:0] req_addr_in,
  input wire logic [DATA_W-1:0] req_wdata_in,
  output logic req_ready_out,
  output logic rsp_valid_out,
  output logic [DATA_W-1:0] rsp_rdata_out,
  // Configuration and status
  input wire logic [SRAM_ADDR_W-1:0] partition_in,
  input wire logic sram_size_32k_in,
  input wire logic battery_backup_in,
  input wire logic internal_memory_disable_n_in,
  output logic loader_request_out,
  // Byte-wide SRAM bus
  output logic [SRAM_ADDR_W-1:0] sram_addr_bus_out,
  output logic [DATA_W-1:0] sram_data_bus_out,
  output logic sram_data_bus_oe_out,
  input wire logic [DATA_W-1:0] sram_data_bus_in,
  output logic primary_chip_select_n_out,
  output logic secondary_chip_select_n_out,
  output logic sram_write_enable_n_out,
  // Expanded bus
  output logic [DATA_W-1:0] low_addr_data_port_out,
  output logic low_addr_data_port_oe_out,
  input wire logic [DATA_W-1:0] low_addr_data_port_in,
  output logic [DATA_W-1:0] high_addr_port_out,
  output logic addr_latch_enable_out,
  output logic expanded_store_n_out,
  output logic expanded_load_n_out,
  output logic program_fetch_enable_n_out,
  output logic program_fetch_enable_oe_out,
  input wire logic program_fetch_enable_n_in
);
  bus_state_t state, next_state;
  logic [3:0] cnt, next_cnt;
  logic [ADDR_W-1:0] addr_q, next_addr_q;
  logic [DATA_W-1:0] wdata_q, next_wdata_q;
  logic write_q, next_write_q;
  logic code_q, next_code_q;
  logic [DATA_W-1:0] rdata, next_rdata;
  logic rsp_valid, next_rsp_valid;
  logic [SRAM_ADDR_W-1:0] sram_addr, next_sram_addr;
  logic [DATA_W-1:0] sram_wdata, next_sram_wdata;
  logic sram_oe, next_sram_oe;
  logic ce1_n, next_ce1_n;
  logic ce2_n, next_ce2_n;
  logic we_n, next_we_n;
  logic [DATA_W-1:0] p0_out, next_p0_out;
  logic p0_oe, next_p0_oe;
  logic [DATA_W-1:0] p2_out, next_p2_out;
  logic ale, next_ale;
  logic store_n, next_store_n;
  logic load_n, next_load_n;
  logic fetch_n, next_fetch_n;
  logic fetch_oe, next_fetch_oe;
  logic loader_req, next_loader_req;

  logic dec_primary;
  logic dec_secondary;
  logic dec_write_ok;
  logic [SRAM_ADDR_W-1:0] dec_sram_addr;
  logic accept;

  nvram_addr_decode u_decode (
    .addr_in(req_addr_in),
    .is_code_in(req_is_code_in),
    .bank2_in(req_bank2_in),
    .partition_in(partition_in),
    .sram_size_32k_in(sram_size_32k_in),
    .ext_only_in(!internal_memory_disable_n_in), // RL3
    .sel_primary_out(dec_primary),
    .sel_secondary_out(dec_secondary),
    .write_ok_out(dec_write_ok),
    .sram_addr_out(dec_sram_addr)
  );

  // No new access while the memory is on backup power
  assign req_ready_out = (state == ST_IDLE) && !battery_backup_in;
  assign accept = req_valid_in && req_ready_out;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_addr_q = addr_q;
    next_wdata_q = wdata_q;
    next_write_q = write_q;
    next_code_q = code_q;
    next_rdata = rdata;
    next_rsp_valid = 1'b0;
    next_sram_addr = sram_addr;
    next_sram_wdata = sram_wdata;
    next_sram_oe = sram_oe;
    next_ce1_n = ce1_n;
    next_ce2_n = ce2_n;
    next_we_n = we_n;
    next_p0_out = p0_out;
    next_p0_oe = p0_oe;
    next_p2_out = p2_out;
    next_ale = 1'b0;
    next_store_n = store_n;
    next_load_n = load_n;
    next_fetch_n = fetch_n;
    case (state)
      ST_IDLE: begin
        if (accept) begin
          next_addr_q = req_addr_in;
          next_wdata_q = req_wdata_in;
          next_write_q = req_write_in;
          next_code_q = req_is_code_in;
          if (dec_primary || dec_secondary) begin
            next_state = ST_SRAM;
            next_cnt = SRAM_CYCLES - CNT_ONE;
            next_sram_addr = dec_sram_addr; // RL4 RL5
            next_ce1_n = !dec_primary; // RL8 RL19
            next_ce2_n = !dec_secondary; // RL9 RL18
            next_we_n = !(req_write_in && dec_write_ok); // RL7
            next_sram_wdata = req_wdata_in; // RL6
            next_sram_oe = req_write_in && dec_write_ok; // RL6
          end else begin
            next_state = ST_EXP_ADDR;
            next_cnt = ALE_CYCLES - CNT_ONE;
            next_ale = 1'b1; // RL13
            next_p0_out = req_addr_in[DATA_W-1:0]; // RL13
            next_p0_oe = 1'b1;
            next_p2_out = req_addr_in[ADDR_W-1:DATA_W]; // RL14
          end
        end
      end
      ST_SRAM: begin
        if (cnt == CNT_ZERO) begin
          next_rdata = sram_data_bus_in; // RL6
          next_ce1_n = 1'b1;
          next_ce2_n = 1'b1;
          next_we_n = 1'b1; // RL19
          next_sram_oe = 1'b0;
          next_state = ST_DONE;
        end else begin
          next_cnt = cnt - CNT_ONE;
        end
      end
      ST_EXP_ADDR: begin
        if (cnt == CNT_ZERO) begin
          next_state = ST_EXP_HOLD;
        end else begin
          next_ale = 1'b1; // RL13
          next_cnt = cnt - CNT_ONE;
        end
      end
      ST_EXP_HOLD: begin
        // Address held one cycle past latch close
        next_state = ST_EXP_STROBE;
        next_cnt = STROBE_CYCLES - CNT_ONE;
        if (code_q) begin
          next_fetch_n = 1'b0; // RL15
          next_p0_oe = 1'b0;
        end else if (write_q) begin
          next_store_n = 1'b0; // RL16
          next_p0_out = wdata_q; // RL13
          next_p0_oe = 1'b1;
        end else begin
          next_load_n = 1'b0; // RL16
          next_p0_oe = 1'b0;
        end
      end
      ST_EXP_STROBE: begin
        if (cnt == CNT_ZERO) begin
          next_rdata = low_addr_data_port_in;
          next_fetch_n = 1'b1;
          next_store_n = 1'b1;
          next_load_n = 1'b1;
          next_p0_oe = 1'b0;
          next_state = ST_DONE;
        end else begin
          next_cnt = cnt - CNT_ONE;
        end
      end
      ST_DONE: begin
        next_rsp_valid = 1'b1;
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin // RL1
      state <= ST_IDLE;
      cnt <= CNT_ZERO;
      addr_q <= '0;
      wdata_q <= '0;
      write_q <= 1'b0;
      code_q <= 1'b0;
      rdata <= '0;
      rsp_valid <= 1'b0;
      sram_addr <= '0;
      sram_wdata <= '0;
      sram_oe <= 1'b0;
      ce1_n <= 1'b1;
      ce2_n <= 1'b1;
      we_n <= 1'b1;
      p0_out <= '0;
      p0_oe <= 1'b0;
      p2_out <= '0;
      ale <= 1'b0;
      store_n <= 1'b1;
      load_n <= 1'b1;
      fetch_n <= 1'b1;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      addr_q <= next_addr_q;
      wdata_q <= next_wdata_q;
      write_q <= next_write_q;
      code_q <= next_code_q;
      rdata <= next_rdata;
      rsp_valid <= next_rsp_valid;
      sram_addr <= next_sram_addr;
      sram_wdata <= next_sram_wdata;
      sram_oe <= next_sram_oe;
      ce1_n <= next_ce1_n;
      ce2_n <= next_ce2_n;
      we_n <= next_we_n;
      p0_out <= next_p0_out;
      p0_oe <= next_p0_oe;
      p2_out <= next_p2_out;
      ale <= next_ale;
      store_n <= next_store_n;
      load_n <= next_load_n;
      fetch_n <= next_fetch_n;
    end
  end

  // Loader request: fetch enable pin sampled while reset is held
  always_comb begin
    next_fetch_oe = 1'b1;
    next_loader_req = loader_req;
    if (reset_in) begin // RL1
      // Pin released so an outside pull can be seen
      next_fetch_oe = 1'b0; // RL2
      next_loader_req = !program_fetch_enable_n_in; // RL2
    end
  end

  always_ff @(posedge clk_sys_in) begin
    fetch_oe <= next_fetch_oe;
    loader_req <= next_loader_req;
  end

  // Selects and write forced off under backup power
  assign primary_chip_select_n_out = ce1_n | battery_backup_in; // RL10
  assign secondary_chip_select_n_out = ce2_n | battery_backup_in; // RL10
  assign sram_write_enable_n_out = we_n | battery_backup_in; // RL19
  assign sram_addr_bus_out = sram_addr;
  assign sram_data_bus_out = sram_wdata;
  assign sram_data_bus_oe_out = sram_oe & !battery_backup_in;
  assign low_addr_data_port_out = p0_out;
  assign low_addr_data_port_oe_out = p0_oe;
  assign high_addr_port_out = p2_out;
  assign addr_latch_enable_out = ale;
  assign expanded_store_n_out = store_n;
  assign expanded_load_n_out = load_n;
  assign program_fetch_enable_n_out = fetch_n;
  assign program_fetch_enable_oe_out = fetch_oe;
  assign rsp_valid_out = rsp_valid;
  assign rsp_rdata_out = rdata;
  assign loader_request_out = loader_req;
endmodule : nvram_bus_ctrl

// *** dv/nvram_mem_model.sv ***
// Far-side SRAM banks and expanded-bus memory
`timescale 1ns/1ps
module nvram_mem_model (
  // Byte-wide side
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [14:0] sa_in,
  input wire logic [7:0] sd_in,
  input wire logic soe_in,
  input wire logic ce1_n_in,
  input wire logic ce2_n_in,
  input wire logic we_n_in,
  output logic [7:0] sd_out,
  // Expanded side
  input wire logic [7:0] p0_in,
  input wire logic p0_oe_in,
  input wire logic [7:0] p2_in,
  input wire logic ale_in,
  input wire logic st_n_in,
  input wire logic ld_n_in,
  input wire logic pf_n_in,
  input wire logic pf_oe_in,
  input wire logic pull_in,
  output logic [7:0] p0_out,
  output logic pf_pin_out
);
  logic [7:0] mem [0:65535];
  logic [7:0] xmem [0:65535];
  logic [7:0] lat = 8'h00;
  logic [7:0] ls = 8'h00;
  logic [7:0] lp = 8'h00;
  wire sel = !(ce1_n_in && ce2_n_in);
  wire [15:0] si = {ce1_n_in, sa_in};
  wire [15:0] xi = {p2_in, lat};
  wire xrd = !ld_n_in || (pf_oe_in && !pf_n_in);
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'(i) ^ 8'h5A;
      xmem[i] = 8'(i) ^ 8'h3C;
    end
  end
  // Released lines show the inverse of the last value
  assign sd_out = soe_in ? sd_in : (sel && we_n_in) ? mem[si] : ~ls;
  assign p0_out = p0_oe_in ? p0_in : xrd ? xmem[xi] : ~lp;
  // Open-drain loader pull, only while in reset
  assign pf_pin_out = (pf_oe_in ? pf_n_in : 1'b1)
    && !(pull_in && reset_in);
  always @(posedge clk_in) begin
    ls <= sd_out;
    lp <= p0_out;
    if (ale_in) begin
      lat <= p0_in;
    end
    if (sel && !we_n_in) begin
      mem[si] <= sd_in;
    end
    if (!st_n_in) begin
      xmem[xi] <= p0_in;
    end
  end
endmodule : nvram_mem_model

// *** dv/nvram_bus_ctrl_checker.sv ***
// Port checker for the bus controller
`timescale 1ns/1ps
module nvram_bus_checker
  import nvram_bus_pkg::*;
(
  // Clock, reset and request
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic req_is_code_in,
  input wire logic req_bank2_in,
  input wire logic [ADDR_W-1:0] req_addr_in,
  input wire logic req_ready_out,
  input wire logic rsp_valid_out,
  // Configuration
  input wire logic [SRAM_ADDR_W-1:0] partition_in,
  input wire logic battery_backup_in,
  input wire logic internal_memory_disable_n_in,
  // Buses
  input wire logic [SRAM_ADDR_W-1:0] sram_addr_bus_out,
  input wire logic sram_data_bus_oe_out,
  input wire logic primary_chip_select_n_out,
  input wire logic secondary_chip_select_n_out,
  input wire logic sram_write_enable_n_out,
  input wire logic [DATA_W-1:0] high_addr_port_out,
  input wire logic addr_latch_enable_out,
  input wire logic expanded_store_n_out,
  input wire logic expanded_load_n_out,
  input wire logic program_fetch_enable_n_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  logic [ADDR_W-1:0] aq;
  wire pn = primary_chip_select_n_out;
  wire sn = secondary_chip_select_n_out;
  wire wn = sram_write_enable_n_out;
  wire ale = addr_latch_enable_out;
  wire tk = req_valid_in && req_ready_out;
  wire ext = tk && req_addr_in[15];
  always_ff @(posedge clk_sys_in) begin
    aq <= req_addr_in;
  end
  sequence s_ale;
    ale [*2] ##1 !ale;
  endsequence
  sequence s_ld;
    !expanded_load_n_out [*4] ##1 expanded_load_n_out;
  endsequence
  property p_reset;
    disable iff (1'b0) reset_in |=> pn && sn && wn && !ale && !rsp_valid_out;
  endproperty
  property p_sel;
    !(!pn && !sn) && (wn || !(pn && sn));
  endproperty
  property p_backup;
    battery_backup_in |-> pn && sn && wn && !sram_data_bus_oe_out;
  endproperty
  property p_addr;
    tk |=> (pn && sn) || sram_addr_bus_out == {~aq[14:13], aq[12:0]};
  endproperty
  property p_protect;
    tk && (req_is_code_in || (!req_bank2_in &&
      req_addr_in[14:0] < partition_in)) |=> wn [*4];
  endproperty
  property p_ext_only;
    tk && !internal_memory_disable_n_in |=> (pn && sn) [*4];
  endproperty
  property p_expand;
    ext |=> (high_addr_port_out == aq[15:8]) ##0 s_ale;
  endproperty
  property p_fetch;
    ext && req_is_code_in |=> ##3 !program_fetch_enable_n_out [*4];
  endproperty
  property p_load;
    ext && !req_is_code_in && !req_write_in |=> ##3 s_ld;
  endproperty
  property p_sec;
    !sn |-> !ale && expanded_load_n_out && expanded_store_n_out;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
  a_sel: assert property (p_sel) else $error("select clash");
  a_backup: assert property (p_backup) else $error("backup drive");
  a_addr: assert property (p_addr) else $error("sram address");
  a_protect: assert property (p_protect) else $error("protected");
  a_ext_only: assert property (p_ext_only) else $error("ext only");
  a_expand: assert property (p_expand) else $error("latch phase");
  a_fetch: assert property (p_fetch) else $error("fetch strobe");
  a_load: assert property (p_load) else $error("load strobe");
  a_sec: assert property (p_sec) else $error("bank2 on ports");
endmodule : nvram_bus_checker

bind nvram_bus_ctrl nvram_bus_checker chk_i (.*);

// *** dv/byte_wide_nvram_bus_interface_tb.sv ***
// Self-checking bench for the bus controller
`timescale 1ns/1ps
module byte_wide_nvram_bus_interface_tb
  import nvram_bus_pkg::*;
;
  typedef struct packed {
    logic [2:0] wcb;
    logic [15:0] a;
    logic [7:0] d;
    logic [7:0] e;
    logic k;
  } row_t;
  logic clk_sys_in = 1'b0, reset_in = 1'b1, loader_pull = 1'b0;
  logic req_valid_in = 1'b0, req_write_in = 1'b0;
  logic req_is_code_in = 1'b0, req_bank2_in = 1'b0;
  logic [ADDR_W-1:0] req_addr_in = 16'h0000;
  logic [DATA_W-1:0] req_wdata_in = 8'h00, sram_data_bus_in;
  logic [DATA_W-1:0] low_addr_data_port_in, rd;
  logic [SRAM_ADDR_W-1:0] partition_in = 15'h0080, sram_addr_bus_out;
  logic sram_size_32k_in = 1'b1, battery_backup_in = 1'b0;
  logic internal_memory_disable_n_in = 1'b1, program_fetch_enable_n_in;
  logic req_ready_out, rsp_valid_out, loader_request_out;
  logic primary_chip_select_n_out, secondary_chip_select_n_out;
  logic sram_write_enable_n_out, sram_data_bus_oe_out;
  logic low_addr_data_port_oe_out, addr_latch_enable_out;
  logic expanded_store_n_out, expanded_load_n_out;
  logic program_fetch_enable_n_out, program_fetch_enable_oe_out;
  logic [DATA_W-1:0] rsp_rdata_out, sram_data_bus_out;
  logic [DATA_W-1:0] low_addr_data_port_out, high_addr_port_out;
  int failures = 0, total_checks = 0;
  row_t rows [0:10] = '{
    {3'h4, 16'h0100, 8'hA5, 8'h00, 1'b0}, {3'h0, 16'h0100, 8'h00, 8'hA5, 1'b1},
    {3'h4, 16'h0010, 8'h33, 8'h00, 1'b0}, {3'h0, 16'h0010, 8'h00, 8'h4A, 1'b1},
    {3'h5, 16'h0200, 8'hC3, 8'h00, 1'b0}, {3'h1, 16'h0200, 8'h00, 8'hC3, 1'b1},
    {3'h0, 16'h0200, 8'h00, 8'h5A, 1'b1}, {3'h4, 16'h9234, 8'h7E, 8'h00, 1'b0},
    {3'h0, 16'h9234, 8'h00, 8'h7E, 1'b1}, {3'h2, 16'h9234, 8'h00, 8'h7E, 1'b1},
    {3'h2, 16'h0010, 8'h00, 8'h4A, 1'b1}};

  nvram_bus_ctrl uut (.*);
  nvram_mem_model partner (.clk_in(clk_sys_in), .reset_in(reset_in),
    .sa_in(sram_addr_bus_out), .sd_in(sram_data_bus_out),
    .soe_in(sram_data_bus_oe_out), .ce1_n_in(primary_chip_select_n_out),
    .ce2_n_in(secondary_chip_select_n_out),
    .we_n_in(sram_write_enable_n_out), .sd_out(sram_data_bus_in),
    .p0_in(low_addr_data_port_out), .p0_oe_in(low_addr_data_port_oe_out),
    .p2_in(high_addr_port_out), .ale_in(addr_latch_enable_out),
    .st_n_in(expanded_store_n_out), .ld_n_in(expanded_load_n_out),
    .pf_n_in(program_fetch_enable_n_out),
    .pf_oe_in(program_fetch_enable_oe_out), .pull_in(loader_pull),
    .p0_out(low_addr_data_port_in), .pf_pin_out(program_fetch_enable_n_in));

  always #25 clk_sys_in = ~clk_sys_in;

  task automatic results();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Called at a rising edge; returns at a rising edge
  task automatic access(input logic [2:0] wcb, input logic [15:0] a,
                        input logic [7:0] d, output logic [7:0] got);
    int n;
    n = 0;
    {req_valid_in, req_write_in, req_is_code_in, req_bank2_in} <= {1'b1, wcb};
    {req_addr_in, req_wdata_in} <= {a, d};
    @(posedge clk_sys_in);
    req_valid_in <= 1'b0;
    while (rsp_valid_out !== 1'b1 && n < 20) begin
      @(negedge clk_sys_in);
      n++;
    end
    if (n == 20) begin
      failures++;
      results();
    end
    got = rsp_rdata_out;
    @(posedge clk_sys_in);
  endtask : access

  initial begin
    @(posedge clk_sys_in);
    loader_pull <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    chk({primary_chip_select_n_out, secondary_chip_select_n_out}, 2'h3);
    @(posedge clk_sys_in);
    reset_in <= 1'b0;
    @(negedge clk_sys_in);
    chk(loader_request_out, 1'b1);
    @(posedge clk_sys_in);
    foreach (rows[i]) begin
      access(rows[i].wcb, rows[i].a, rows[i].d, rd);
      if (rows[i].k) chk(rd, rows[i].e);
    end
    partition_in <= 15'h0000;
    access(3'h4, 16'h0010, 8'h66, rd);
    access(3'h0, 16'h0010, 8'h00, rd);
    chk(rd, 8'h66);
    sram_size_32k_in <= 1'b0;
    access(3'h4, 16'h3000, 8'h11, rd);
    sram_size_32k_in <= 1'b1;
    access(3'h0, 16'h3000, 8'h00, rd);
    chk(rd, 8'h5A);
    internal_memory_disable_n_in <= 1'b0;
    access(3'h0, 16'h0100, 8'h00, rd);
    chk(rd, 8'h3C);
    internal_memory_disable_n_in <= 1'b1;
    // Backup power arrives in mid-write: selects and write forced off
    {req_valid_in, req_write_in, req_addr_in} <= {2'h3, 16'h0300};
    req_wdata_in <= 8'h99;
    @(posedge clk_sys_in);
    req_valid_in <= 1'b0;
    battery_backup_in <= 1'b1;
    @(negedge clk_sys_in);
    chk({primary_chip_select_n_out, sram_write_enable_n_out}, 2'h3);
    chk(sram_data_bus_oe_out, 1'b0);
    repeat (2) @(posedge clk_sys_in);
    battery_backup_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    access(3'h0, 16'h0300, 8'h00, rd);
    chk(rd, 8'h5A);
    battery_backup_in <= 1'b1;
    @(negedge clk_sys_in);
    chk(req_ready_out, 1'b0);
    chk({primary_chip_select_n_out, sram_write_enable_n_out}, 2'h3);
    @(posedge clk_sys_in);
    battery_backup_in <= 1'b0;
    loader_pull <= 1'b0;
    reset_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    @(negedge clk_sys_in);
    chk(loader_request_out, 1'b0);
    results();
  end
endmodule : byte_wide_nvram_bus_interface_tb
